//--- rtl/dual_switch_fault_manager.sv
module dual_switch_fault_manager
   import fault_mgr_pkg::*;
#(
   parameter int CW = 17
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Host configuration and reads
   input  wire logic             ganged_mode,
   input  wire logic             cfg_wr,
   input  wire logic             cfg_wr_bank,
   input  wire bank_cfg_t        cfg_wr_data,
   input  wire logic [NCH-1:0]   fault_rd,
   // Per-channel indications
   input  wire chan_ind_t        ind_ch0,
   input  wire chan_ind_t        ind_ch1,
   input  wire logic [NCH-1:0]   sw_mode,
   // Pins
   input  wire logic             direct_input_ch0,
   input  wire logic             direct_input_ch1,
   input  wire logic [NCH-1:0]   load_profile_select,
   // Switching and sensing
   output logic [NCH-1:0]        chan_on,
   output logic [NCH-1:0]        sense_en,
   output logic                  sense_valid_strobe_n,
   output logic                  fault_pin_n,
   // Readback
   output bank_cfg_t             cfg_rb_ch0,
   output bank_cfg_t             cfg_rb_ch1,
   output logic [FS_W-1:0]       fault_status_reg_ch0,
   output logic [FS_W-1:0]       fault_status_reg_ch1,
   output logic [RC_W-1:0]       retry_count_reg_ch0,
   output logic [RC_W-1:0]       retry_count_reg_ch1,
   output logic [NCH-1:0]        profile_motor
);

   bank_cfg_t       cfg_r [NCH];
   bank_cfg_t       eff   [NCH];
   chan_ind_t       ind   [NCH];
   logic [NCH-1:0]  din_s1_r, din_s2_r, load_profile_select_s1_r, load_profile_select_s2_r;
   logic            gang_d_r;
   logic [NCH-1:0]  fc, fc_e, fcd_r, fc_rise;
   logic [NCH-1:0]  latched_r, rwait_r, lat_nxt, rw_nxt, on_nxt;
   logic [RC_W-1:0] rcnt_r [NCH];
   logic [RC_W-1:0] rcnt_nxt [NCH];
   logic [FS_W-1:0] fstat_r [NCH];
   logic [NCH-1:0]  motor, trip, win_act, start;
   logic [NCH-1:0]  oc_e, sc_e, ot_e, flt_e, can_retry, cool, retry_go;
   logic            ot_hold_r, ot_hold_nxt, any_hot;

   assign ind[0] = ind_ch0;
   assign ind[1] = ind_ch1;

   // Flag update in which a hardware set beats a simultaneous clear.
   function automatic logic upd(input logic cur, input logic set, input logic clr);
      upd = set | (cur & ~clr);
   endfunction

   // Bank 1 image of a bank 0 word, keeping bank 1's own diagnostic bits.
   function automatic bank_cfg_t mirror(input bank_cfg_t src, input bank_cfg_t own);
      mirror = src;
      mirror.chan_cfg[DIAG_HI:DIAG_LO] = own.chan_cfg[DIAG_HI:DIAG_LO];
   endfunction

   // Pins cross into the clock domain through two flip-flops each.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         din_s1_r  <= '0;
         din_s2_r  <= '0;
         load_profile_select_s1_r <= '0;
         load_profile_select_s2_r <= '0;
      end else begin
         din_s1_r  <= {direct_input_ch1, direct_input_ch0};
         din_s2_r  <= din_s1_r;
         load_profile_select_s1_r <= load_profile_select;
         load_profile_select_s2_r <= load_profile_select_s1_r;
      end
   end

   // Configuration banks; bank 1 follows bank 0 while ganged.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_r[0] <= BANK_RST;
         cfg_r[1] <= BANK_RST;
         gang_d_r <= 1'b0;
      end else begin
         gang_d_r <= ganged_mode;
         if (ganged_mode && !gang_d_r) begin
            cfg_r[1] <= mirror(cfg_r[0], cfg_r[1]);
         end
         if (cfg_wr && !cfg_wr_bank) begin
            cfg_r[0] <= cfg_wr_data;
            if (ganged_mode) begin
               cfg_r[1] <= mirror(cfg_wr_data, cfg_r[1]);
            end
         end else if (cfg_wr && cfg_wr_bank) begin
            if (ganged_mode) begin
               cfg_r[1].chan_cfg[DIAG_HI:DIAG_LO] <= cfg_wr_data.chan_cfg[DIAG_HI:DIAG_LO];
            end else begin
               cfg_r[1] <= cfg_wr_data;
            end
         end
      end
   end

   // Fault control, events and retry decisions for both channels.
   always_comb begin
      any_hot = ind[0].overtemp | ind[1].overtemp;
      for (int x = 0; x < NCH; x++) begin
         eff[x]   = ganged_mode ? cfg_r[0] : cfg_r[x];
         fc[x]    = cfg_r[x].duty[DUTY_ON_BIT] | din_s2_r[x];
         motor[x] = load_profile_select_s2_r[ganged_mode ? 0 : x] ^ eff[x].retry.profile_src;
      end
      // channel 0 fault control governs both
      fc_e    = ganged_mode ? {NCH{fc[0]}} : fc;
      fc_rise = fc_e & ~fcd_r;
      for (int x = 0; x < NCH; x++) begin
         oc_e[x] = trip[x];
         sc_e[x] = ind[x].severe & chan_on[x];
         ot_e[x] = ind[x].overtemp & chan_on[x];
      end
      if (ganged_mode) begin
         oc_e = {NCH{|oc_e}};
         sc_e = {NCH{|sc_e}};
         ot_e = {NCH{|ot_e}};
      end
      flt_e = oc_e | sc_e | ot_e;
      for (int x = 0; x < NCH; x++) begin
         can_retry[x] = eff[x].retry.retry_en && (rcnt_r[x] < eff[x].retry.retry_limit);
         cool[x]      = ganged_mode ? ~any_hot : ~ind[x].overtemp;
         retry_go[x]  = rwait_r[x] & cool[x] & ~flt_e[x];
         lat_nxt[x]   = flt_e[x] & ~can_retry[x] | (latched_r[x] & ~fc_rise[x]);
         rw_nxt[x]    = flt_e[x] & can_retry[x]
                        | (rwait_r[x] & ~retry_go[x] & ~fc_rise[x]);
         rcnt_nxt[x]  = fc_rise[x] ? RETRY_CNT_RST
                        : retry_go[x] ? rcnt_r[x] + RC_W'(1) : rcnt_r[x];
         on_nxt[x]    = fc_e[x] & ~lat_nxt[x] & ~rw_nxt[x];
         start[x]     = on_nxt[x] & ~chan_on[x];
      end
      // hold until cool and a turn-on
      ot_hold_nxt = any_hot | (ot_hold_r & ~(|start));
   end

   // Latch, retry and switching state.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fcd_r     <= '0;
         latched_r <= '0;
         rwait_r   <= '0;
         chan_on   <= '0;
         rcnt_r[0] <= RETRY_CNT_RST;
         rcnt_r[1] <= RETRY_CNT_RST;
      end else begin
         fcd_r     <= fc_e;
         rcnt_r[0] <= rcnt_nxt[0];
         if (ganged_mode) begin
            latched_r <= {NCH{lat_nxt[0]}};
            rwait_r   <= {NCH{rw_nxt[0]}};
            chan_on   <= {NCH{on_nxt[0]}};
            rcnt_r[1] <= rcnt_nxt[0];
         end else begin
            latched_r <= lat_nxt;
            rwait_r   <= rw_nxt;
            chan_on   <= on_nxt;
            rcnt_r[1] <= rcnt_nxt[1];
         end
      end
   end

   // Fault pin: low while any fault is pending, latched or overtemp-held.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ot_hold_r   <= 1'b0;
         fault_pin_n <= 1'b1;
      end else begin
         ot_hold_r   <= ot_hold_nxt;
         fault_pin_n <= ~(ot_hold_nxt | (|lat_nxt) | (|rw_nxt) | (|flt_e));
      end
   end

   // Fault status registers; reads clear only what is safe to clear.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fstat_r[0] <= FAULT_RST;
         fstat_r[1] <= FAULT_RST;
      end else begin
         for (int x = 0; x < NCH; x++) begin
            fstat_r[x][OD_OC] <= upd(fstat_r[x][OD_OC], oc_e[x],
                                     fault_rd[x] & ~lat_nxt[x] & ~rw_nxt[x]);
            fstat_r[x][OD_SC] <= upd(fstat_r[x][OD_SC], sc_e[x],
                                     fault_rd[x] & ~lat_nxt[x] & ~rw_nxt[x]);
            // clear needs cool and pin high
            fstat_r[x][OD_OT] <= upd(fstat_r[x][OD_OT], ot_e[x],
                                     fault_rd[x] & ~ind[x].overtemp & fault_pin_n);
            fstat_r[x][OD_OS] <= upd(fstat_r[x][OD_OS],
                                     ind[x].os & cfg_r[x].chan_cfg[CC_OS_EN], fault_rd[x]);
            fstat_r[x][OD_OPEN_LOAD_ON_FLAG] <= upd(fstat_r[x][OD_OPEN_LOAD_ON_FLAG],
                                       ind[x].open_load_on_flag & chan_on[x]
                                       & cfg_r[x].chan_cfg[CC_OPEN_LOAD_ON_FLAG_EN], fault_rd[x]);
            fstat_r[x][OD_OPEN_LOAD_OFF_FLAG] <= upd(fstat_r[x][OD_OPEN_LOAD_OFF_FLAG],
                                        ind[x].open_load_off_flag & ~chan_on[x]
                                        & cfg_r[x].chan_cfg[CC_OPEN_LOAD_OFF_FLAG_EN], fault_rd[x]);
            fstat_r[x][FS_W-1:OD_OPEN_LOAD_OFF_FLAG+1] <= '0;
         end
      end
   end

   // One overcurrent profile per channel.
   for (genvar g = 0; g < NCH; g++) begin : g_prof
      ovc_profile #(.CW(CW)) u_prof (
         .clk        (clk),
         .rstn       (rstn),
         .on         (chan_on[g]),
         .start      (start[g]),
         .clr        (fc_rise[g]),
         .motor      (motor[g]),
         .sw_mode    (sw_mode[g]),
         .thr_low    (ind[g].thr_low),
         .thr_mid    (ind[g].thr_mid),
         .thr_high   (ind[g].thr_high),
         .w1         (eff[g].win1),
         .w2         (eff[g].win2),
         .trip       (trip[g]),
         .win_active (win_act[g])
      );
   end

   // Sensing is blanked while a window runs, since readings are meaningless then.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sense_en             <= '0;
         sense_valid_strobe_n <= 1'b1;
         profile_motor        <= '0;
      end else begin
         sense_en             <= chan_on & ~win_act;
         sense_valid_strobe_n <= ~(|(chan_on & ~win_act));
         profile_motor        <= motor;
      end
   end

   // Readback straight from the state registers.
   assign cfg_rb_ch0           = cfg_r[0];
   assign cfg_rb_ch1           = cfg_r[1];
   assign fault_status_reg_ch0 = fstat_r[0];
   assign fault_status_reg_ch1 = fstat_r[1];
   assign retry_count_reg_ch0  = rcnt_r[0];
   assign retry_count_reg_ch1  = rcnt_r[1];

endmodule

//--- rtl/fault_mgr_pkg.sv
package fault_mgr_pkg;

   // Channel count and field widths.
   localparam int NCH   = 2;
   localparam int CFG_W = 9;
   localparam int WIN_W = 16;
   localparam int RC_W  = 4;
   localparam int FS_W  = 8;

   // Bit positions inside the bank configuration words.
   localparam int DUTY_ON_BIT  = 8;
   localparam int CC_OPEN_LOAD_OFF_FLAG_EN  = 6;
   localparam int CC_OPEN_LOAD_ON_FLAG_EN   = 7;
   localparam int CC_OS_EN     = 8;
   localparam int DIAG_LO      = 6;
   localparam int DIAG_HI      = 8;
   localparam int OC_SENSE_BIT = 5;

   // Bit positions inside each fault status register.
   localparam int OD_OC    = 0;
   localparam int OD_SC    = 1;
   localparam int OD_OT    = 2;
   localparam int OD_OS    = 3;
   localparam int OD_OPEN_LOAD_ON_FLAG  = 4;
   localparam int OD_OPEN_LOAD_OFF_FLAG = 5;

   // Values after reset.
   localparam logic [RC_W-1:0] RETRY_CNT_RST = 4'h0;
   localparam logic [FS_W-1:0] FAULT_RST     = 8'h00;

   // Retry configuration of one bank.
   typedef struct packed {
      logic            retry_en;
      logic            profile_src;
      logic [RC_W-1:0] retry_limit;
   } retry_cfg_t;

   // One bank of host-written configuration.
   typedef struct packed {
      logic [CFG_W-1:0] duty;
      logic [CFG_W-1:0] chan_cfg;
      logic [CFG_W-1:0] ovc_cfg;
      retry_cfg_t       retry;
      logic [WIN_W-1:0] win1;
      logic [WIN_W-1:0] win2;
   } bank_cfg_t;

   localparam bank_cfg_t BANK_RST = '0;

   // Per-channel comparator and detector indications.
   typedef struct packed {
      logic thr_low;
      logic thr_mid;
      logic thr_high;
      logic overtemp;
      logic severe;
      logic open_load_on_flag;
      logic open_load_off_flag;
      logic os;
   } chan_ind_t;

   // Overcurrent profile states.
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_WIN1   = 4'b0010,
      ST_WIN2   = 4'b0100,
      ST_STEADY = 4'b1000
   } prof_st_t;

endpackage

//--- rtl/ovc_profile.sv
module ovc_profile
   import fault_mgr_pkg::*;
#(
   parameter int CW = 17
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Control
   input  wire logic             on,
   input  wire logic             start,
   input  wire logic             clr,
   input  wire logic             motor,
   input  wire logic             sw_mode,
   // Comparators and window widths
   input  wire logic             thr_low,
   input  wire logic             thr_mid,
   input  wire logic             thr_high,
   input  wire logic [WIN_W-1:0] w1,
   input  wire logic [WIN_W-1:0] w2,
   // Results
   output logic                  trip,
   output logic                  win_active
);

   // The counter must be able to pass the widest window.
   if (CW <= WIN_W) begin : g_chk
      $error("ovc_profile: CW must exceed WIN_W");
   end

   prof_st_t        st_r;
   logic [CW-1:0]   cnt_r;
   logic            started_r;
   logic [CW-1:0]   cnt_inc;

   // Saturating increment keeps a stuck window from wrapping to zero.
   assign cnt_inc = (&cnt_r) ? cnt_r : cnt_r + CW'(1);

   assign win_active = (st_r == ST_WIN1) || (st_r == ST_WIN2);

   // Profile sequencing; time is only counted while the channel is on.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r      <= ST_IDLE;
         cnt_r     <= '0;
         started_r <= 1'b0;
         trip      <= 1'b0;
      end else begin
         trip <= 1'b0;
         if (clr) begin
            started_r <= 1'b0;
            cnt_r     <= '0;
            st_r      <= ST_IDLE;
         end
         if (start && !motor && (!sw_mode || !started_r)) begin
            st_r      <= ST_WIN1;
            cnt_r     <= '0;
            started_r <= 1'b1;
         end else if (on && !clr) begin
            case (st_r)
               ST_IDLE: begin
                  st_r <= ST_STEADY;
               end
               ST_WIN1: begin
                  if (thr_high || (motor && cnt_r > CW'(w1))) begin
                     trip <= 1'b1;
                     st_r <= ST_IDLE;
                  end else if (motor && !thr_low) begin
                     st_r <= ST_STEADY;
                     if (!sw_mode) begin
                        cnt_r <= '0;
                     end
                  end else if (!motor && cnt_r > CW'(w1)) begin
                     st_r  <= ST_WIN2;
                     cnt_r <= '0;
                  end else begin
                     cnt_r <= cnt_inc;
                  end
               end
               ST_WIN2: begin
                  if (thr_high || thr_mid) begin
                     trip <= 1'b1;
                     st_r <= ST_IDLE;
                  end else if (cnt_r > CW'(w2)) begin
                     st_r <= ST_STEADY;
                  end else begin
                     cnt_r <= cnt_inc;
                  end
               end
               ST_STEADY: begin
                  if (motor && thr_low) begin
                     st_r <= ST_WIN1;
                  end else if (thr_low) begin
                     trip <= 1'b1;
                     st_r <= ST_IDLE;
                  end
               end
               default: begin
                  st_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

//--- sim/fault_mgr_props.sv
module fault_mgr_props
   import fault_mgr_pkg::*;
#(
   parameter int CW = 17
) (
   // Clock and reset
   input wire logic             clk,
   input wire logic             rstn,
   // Host requests and indications
   input wire logic             ganged_mode,
   input wire logic             cfg_wr,
   input wire logic             cfg_wr_bank,
   input wire bank_cfg_t        cfg_wr_data,
   input wire chan_ind_t        ind_ch0,
   input wire chan_ind_t        ind_ch1,
   // Switch state and readback
   input wire logic [NCH-1:0]   chan_on,
   input wire logic             sense_valid_strobe_n,
   input wire logic             fault_pin_n,
   input wire bank_cfg_t        cfg_rb_ch0,
   input wire bank_cfg_t        cfg_rb_ch1,
   input wire logic [FS_W-1:0]  fault_status_reg_ch0,
   input wire logic [FS_W-1:0]  fault_status_reg_ch1,
   input wire logic [RC_W-1:0]  retry_count_reg_ch0,
   input wire logic [RC_W-1:0]  retry_count_reg_ch1
);
   timeunit 1ns;
   timeprecision 1ps;

   // One clock domain, so clock and reset are given once.
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // A short on either tied channel stops both and flags both.
   a_gang_severe_both: assert property (
      ganged_mode && chan_on == 2'b11 && (ind_ch0.severe || ind_ch1.severe) |=>
      chan_on == 2'b00 && fault_status_reg_ch0[OD_SC] && fault_status_reg_ch1[OD_SC])
      else $error("severe short did not stop and flag both channels");
   // Overheating while on stops the channel at once.
   a_ot_stops_chan: assert property (
      !ganged_mode && chan_on[0] && ind_ch0.overtemp |=>
      !chan_on[0] && fault_status_reg_ch0[OD_OT] && !fault_pin_n)
      else $error("overtemperature did not stop channel 0");
   // The fault pin cannot rise while any channel is still hot.
   a_ot_pin_hold: assert property (
      !fault_pin_n && (ind_ch0.overtemp || ind_ch1.overtemp) |=> !fault_pin_n)
      else $error("fault pin rose while hot");
   // Sensing needs a live channel, so an idle switch keeps the strobe high.
   a_idle_no_sense: assert property (
      (chan_on == 2'b00) [*2] |=> sense_valid_strobe_n)
      else $error("sense strobe active with both channels off");
   // Entering paired mode copies bank 0 but keeps the diagnostic enables.
   a_gang_entry_copy: assert property (
      $rose(ganged_mode) && !cfg_wr |=>
      cfg_rb_ch1.ovc_cfg == $past(cfg_rb_ch0.ovc_cfg) &&
      cfg_rb_ch1.chan_cfg[5:0] == $past(cfg_rb_ch0.chan_cfg[5:0]) &&
      cfg_rb_ch1.chan_cfg[DIAG_HI:DIAG_LO] == $past(cfg_rb_ch1.chan_cfg[DIAG_HI:DIAG_LO]))
      else $error("bank 1 not copied on paired entry");
   // Bank 0 writes refresh bank 1 while paired.
   a_bank0_refresh: assert property (
      ganged_mode && cfg_wr && !cfg_wr_bank |=>
      cfg_rb_ch1.duty == $past(cfg_wr_data.duty) && cfg_rb_ch0.win1 == $past(cfg_wr_data.win1))
      else $error("bank 0 write not mirrored into bank 1");
   // Bank 1 switching settings ignore bank 1 writes while paired.
   a_bank1_frozen: assert property (
      ganged_mode [*2] ##0 (cfg_wr && cfg_wr_bank) |=>
      cfg_rb_ch1.duty == $past(cfg_rb_ch1.duty))
      else $error("bank 1 duty changed by its own write while paired");
   // One retry counter serves both paired channels.
   a_retry_mirror: assert property (
      ganged_mode [*3] |-> retry_count_reg_ch1 == retry_count_reg_ch0)
      else $error("channel 1 retry count differs while paired");
endmodule

bind dual_switch_fault_manager fault_mgr_props #(.CW(CW)) fault_mgr_props_i (
   .clk(clk), .rstn(rstn), .ganged_mode(ganged_mode), .cfg_wr(cfg_wr),
   .cfg_wr_bank(cfg_wr_bank), .cfg_wr_data(cfg_wr_data), .ind_ch0(ind_ch0),
   .ind_ch1(ind_ch1), .chan_on(chan_on), .sense_valid_strobe_n(sense_valid_strobe_n),
   .fault_pin_n(fault_pin_n), .cfg_rb_ch0(cfg_rb_ch0), .cfg_rb_ch1(cfg_rb_ch1),
   .fault_status_reg_ch0(fault_status_reg_ch0), .fault_status_reg_ch1(fault_status_reg_ch1),
   .retry_count_reg_ch0(retry_count_reg_ch0), .retry_count_reg_ch1(retry_count_reg_ch1));

//--- sim/host_model.sv
module host_model
   import fault_mgr_pkg::*;
(
   // Clock
   input  wire logic            clk,
   // Requests to the switch
   output logic                 ganged_mode,
   output logic                 cfg_wr,
   output logic                 cfg_wr_bank,
   output bank_cfg_t            cfg_wr_data,
   output logic [NCH-1:0]       fault_rd
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle at time zero; idle data is inverted so a stale word never looks fresh.
   initial begin
      ganged_mode = 1'b0;
      cfg_wr      = 1'b0;
      cfg_wr_bank = 1'b0;
      cfg_wr_data = '1;
      fault_rd    = '0;
   end

   // One whole word per strobe, held for exactly one sampling edge.
   task automatic wr(input logic bank, input bank_cfg_t data);
      @(posedge clk);
      cfg_wr      <= 1'b1;
      cfg_wr_bank <= bank;
      cfg_wr_data <= data;
      @(posedge clk);
      cfg_wr      <= 1'b0;
      cfg_wr_data <= ~data;
   endtask

   // Clear-on-read pulse for the chosen fault registers.
   task automatic rd(input logic [NCH-1:0] ch);
      @(posedge clk);
      fault_rd <= ch;
      @(posedge clk);
      fault_rd <= '0;
   endtask

   task automatic gang(input logic v);
      @(posedge clk);
      ganged_mode <= v;
   endtask

   task automatic delatch(input bank_cfg_t data);
      bank_cfg_t w;
      w = data;
      w.duty[DUTY_ON_BIT] = 1'b0;
      wr(1'b0, w);
      wr(1'b0, data);
   endtask
endmodule

//--- sim/tb.sv
`define CHK(nm, e, a) \
   begin \
      checked++; \
      if ((a) !== (e)) begin \
         failures++; \
         $display("wrong value %s: expected %h, seen %h", nm, e, a); \
      end \
   end

module tb
   import fault_mgr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             clk = 1'b0;
   logic             rstn = 1'b0;
   logic             ganged_mode, cfg_wr, cfg_wr_bank;
   bank_cfg_t        cfg_wr_data, cfg_rb_ch0, cfg_rb_ch1;
   logic [NCH-1:0]   fault_rd, sw_mode, load_profile_select;
   chan_ind_t        ind_ch0, ind_ch1;
   logic             direct_input_ch0, direct_input_ch1;
   logic [NCH-1:0]   chan_on, sense_en, profile_motor;
   logic             sense_valid_strobe_n, fault_pin_n;
   logic [FS_W-1:0]  fault_status_reg_ch0, fault_status_reg_ch1;
   logic [RC_W-1:0]  retry_count_reg_ch0, retry_count_reg_ch1;
   int               failures = 0;
   int               checked = 0;

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   dual_switch_fault_manager #(.CW(17)) dual_switch_fault_manager_i (
      .clk(clk), .rstn(rstn), .ganged_mode(ganged_mode), .cfg_wr(cfg_wr),
      .cfg_wr_bank(cfg_wr_bank), .cfg_wr_data(cfg_wr_data), .fault_rd(fault_rd),
      .ind_ch0(ind_ch0), .ind_ch1(ind_ch1), .sw_mode(sw_mode),
      .direct_input_ch0(direct_input_ch0), .direct_input_ch1(direct_input_ch1),
      .load_profile_select(load_profile_select), .chan_on(chan_on), .sense_en(sense_en),
      .sense_valid_strobe_n(sense_valid_strobe_n), .fault_pin_n(fault_pin_n),
      .cfg_rb_ch0(cfg_rb_ch0), .cfg_rb_ch1(cfg_rb_ch1),
      .fault_status_reg_ch0(fault_status_reg_ch0), .fault_status_reg_ch1(fault_status_reg_ch1),
      .retry_count_reg_ch0(retry_count_reg_ch0), .retry_count_reg_ch1(retry_count_reg_ch1),
      .profile_motor(profile_motor));

   host_model host_model_i (
      .clk(clk), .ganged_mode(ganged_mode), .cfg_wr(cfg_wr), .cfg_wr_bank(cfg_wr_bank),
      .cfg_wr_data(cfg_wr_data), .fault_rd(fault_rd));

   // Config word with window widths of 8 (10 cycles each) and a retry limit of two.
   function automatic bank_cfg_t word(input logic on, input logic [8:0] cc,
                                      input logic ren, input logic src);
      bank_cfg_t w;
      w = BANK_RST;
      w.duty = {on, 8'hFF};
      w.chan_cfg = cc;
      w.ovc_cfg = 9'h020;
      w.retry = '{ren, src, 4'h2};
      w.win1 = 16'h0008;
      w.win2 = 16'h0008;
      return w;
   endfunction

   task automatic nap(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Bounded wait; the caller judges the outcome.
   task automatic wait_on(input logic [1:0] m);
      for (int i = 0; i < 40 && chan_on !== m; i++) begin
         @(negedge clk);
      end
   endtask

   task automatic t_profile();
      nap(4);
      `CHK("profile after reset", 2'b10, profile_motor)
      host_model_i.wr(1'b0, word(1'b0, 9'h000, 1'b0, 1'b1));
      nap(3);
      `CHK("profile inverted", 2'b11, profile_motor)
   endtask

   task automatic t_overcurrent();
      host_model_i.wr(1'b0, word(1'b1, 9'h000, 1'b0, 1'b0));
      wait_on(2'b01);
      nap(4);
      `CHK("blanked in first window", 1'b1, sense_valid_strobe_n)
      `CHK("sense off in window", 2'b00, sense_en)
      nap(24);
      `CHK("sensing after windows", 1'b0, sense_valid_strobe_n)
      `CHK("sense on after windows", 2'b01, sense_en)
      @(posedge clk);
      ind_ch0.thr_low <= 1'b1;
      wait_on(2'b00);
      `CHK("oc flag", 1'b1, fault_status_reg_ch0[OD_OC])
      `CHK("pin after trip", 1'b0, fault_pin_n)
      @(posedge clk);
      ind_ch0.thr_low <= 1'b0;
      nap(4);
      `CHK("latched without retry", 2'b00, chan_on)
      host_model_i.delatch(word(1'b1, 9'h000, 1'b0, 1'b0));
      wait_on(2'b01);
      `CHK("on after delatch", 2'b01, chan_on)
      `CHK("pin after delatch", 1'b1, fault_pin_n)
   endtask

   task automatic t_overtemp();
      host_model_i.wr(1'b0, word(1'b1, 9'h000, 1'b1, 1'b0));
      @(posedge clk);
      ind_ch0.overtemp <= 1'b1;
      wait_on(2'b00);
      `CHK("ot flag", 1'b1, fault_status_reg_ch0[OD_OT])
      host_model_i.rd(2'b01);
      nap(2);
      `CHK("ot flag kept while hot", 1'b1, fault_status_reg_ch0[OD_OT])
      @(posedge clk);
      ind_ch0.overtemp <= 1'b0;
      wait_on(2'b01);
      `CHK("retry turn-on", 2'b01, chan_on)
      `CHK("retry count", 4'h1, retry_count_reg_ch0)
      `CHK("pin after cool turn-on", 1'b1, fault_pin_n)
      host_model_i.rd(2'b01);
      nap(2);
      `CHK("ot flag cleared", 1'b0, fault_status_reg_ch0[OD_OT])
      @(posedge clk);
      ind_ch1.overtemp <= 1'b1;
      nap(3);
      @(posedge clk);
      ind_ch1.overtemp <= 1'b0;
      nap(3);
      `CHK("pin held after off-state ot", 1'b0, fault_pin_n)
      host_model_i.delatch(word(1'b1, 9'h000, 1'b1, 1'b0));
      nap(3);
      `CHK("pin after turn-on", 1'b1, fault_pin_n)
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         ind_ch0.severe <= 1'b1;
         @(posedge clk);
         ind_ch0.severe <= 1'b0;
         nap(6);
      end
      `CHK("latched after retries", 2'b00, chan_on)
      `CHK("retries used", 4'h2, retry_count_reg_ch0)
   endtask

   task automatic t_ganged();
      host_model_i.wr(1'b1, word(1'b0, 9'h140, 1'b0, 1'b0));
      host_model_i.wr(1'b0, word(1'b0, 9'h025, 1'b0, 1'b0));
      host_model_i.gang(1'b1);
      nap(2);
      `CHK("bank 1 chan cfg", 9'h165, cfg_rb_ch1.chan_cfg)
      `CHK("bank 1 duty", 9'h0FF, cfg_rb_ch1.duty)
      host_model_i.wr(1'b0, word(1'b1, 9'h025, 1'b0, 1'b0));
      wait_on(2'b11);
      `CHK("both on from bank 0", 2'b11, chan_on)
      `CHK("bank 1 refreshed", 9'h1FF, cfg_rb_ch1.duty)
      host_model_i.wr(1'b1, word(1'b0, 9'h025, 1'b0, 1'b0));
      nap(3);
      `CHK("bank 1 write ignored", 2'b11, chan_on)
      `CHK("bank 1 duty kept", 9'h1FF, cfg_rb_ch1.duty)
      `CHK("bank 1 diag taken", 9'h025, cfg_rb_ch1.chan_cfg)
      @(posedge clk);
      ind_ch1.severe <= 1'b1;
      @(posedge clk);
      ind_ch1.severe <= 1'b0;
      wait_on(2'b00);
      `CHK("sc in both", 2'b11, {fault_status_reg_ch1[OD_SC], fault_status_reg_ch0[OD_SC]})
      host_model_i.delatch(word(1'b1, 9'h025, 1'b0, 1'b0));
      wait_on(2'b11);
      `CHK("both released via bank 0", 2'b11, chan_on)
      host_model_i.gang(1'b0);
   endtask

   // Motor profile: current above the lower level opens a timed window, not a trip.
   task automatic t_motor();
      host_model_i.wr(1'b0, word(1'b1, 9'h000, 1'b0, 1'b1));
      nap(4);
      @(posedge clk);
      ind_ch0.thr_low <= 1'b1;
      nap(3);
      `CHK("motor window tolerates", 2'b11, chan_on)
      `CHK("sense blanked in window", 2'b10, sense_en)
      wait_on(2'b10);
      `CHK("motor window expiry", 2'b10, chan_on)
      `CHK("motor oc flag", 1'b1, fault_status_reg_ch0[OD_OC])
      @(posedge clk);
      ind_ch0.thr_low <= 1'b0;
   endtask

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Main sequence: quiet inputs, reset, then the scenarios in turn.
   initial begin
      ind_ch0 = '0;
      ind_ch1 = '0;
      sw_mode = 2'b00;
      direct_input_ch0 = 1'b0;
      direct_input_ch1 = 1'b0;
      load_profile_select = 2'b10;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      `CHK("chan_on at reset", 2'b00, chan_on)
      `CHK("pin at reset", 1'b1, fault_pin_n)
      t_profile();
      t_overcurrent();
      t_overtemp();
      t_ganged();
      t_motor();
      test_done();
   end

   // Scenarios need well under 2000 cycles; a hang is cut at 20000.
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done();
   end
endmodule
